// File: rtl/awc_alu.sv
`timescale 1ns/1ps
module awc_alu (
    input wire logic clk,
    input wire logic sys_rst,
    input awc_pkg::awc_req_t req,
    output logic wb_valid,
    output logic [7:0] wb_dst_data,
    output logic [7:0] wb_src_data,
    output awc_pkg::awc_flags_t flags
);

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    // 9-bit add of two bytes plus carry
    function automatic logic [8:0] awc_add9(input logic [7:0] a, input logic [7:0] b, input logic ci);
        awc_add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    endfunction

    function automatic logic [4:0] awc_add5(input logic [3:0] a, input logic [3:0] b, input logic ci);
        awc_add5 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
    endfunction

    // top bit of a byte, the two's complement sign
    function automatic logic awc_msb(input logic [7:0] a);
        awc_msb = a[awc_pkg::MSB_POS];
    endfunction

    // high when every bit of the byte is clear
    function automatic logic awc_is_zero(input logic [7:0] a);
        awc_is_zero = (a == 8'h00);
    endfunction

    // like-signed operands giving an unlike-signed sum
    function automatic logic awc_ovf(input logic a_sign, input logic b_sign, input logic r_sign);
        awc_ovf = (a_sign == b_sign) && (r_sign != a_sign);
    endfunction

    // idle cycles keep the last answer
    function automatic logic [7:0] awc_hold8(input logic tk, input logic [7:0] nv, input logic [7:0] ov);
        awc_hold8 = tk ? nv : ov;
    endfunction

    function automatic logic awc_hold1(input logic tk, input logic nv, input logic ov);
        awc_hold1 = tk ? nv : ov;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // operand split

    wire logic req_valid = req.valid;
    wire logic [7:0] op_dst = req.dst;
    wire logic [7:0] op_src = req.src;
    wire logic op_cin = req.carry_in;

    wire logic [3:0] op_dst_lo = op_dst[awc_pkg::NIB_W-1:0];
    wire logic [3:0] op_src_lo = op_src[awc_pkg::NIB_W-1:0];

    // a request is only taken outside reset
    wire logic take = req_valid && !sys_rst;

    ////////////////////////////////////////////////////////////////////////
    // adder

    wire logic [8:0] sum_full = awc_add9(op_dst, op_src, op_cin);
    wire logic [7:0] sum = sum_full[awc_pkg::DATA_W-1:0];
    wire logic carry_out = sum_full[awc_pkg::DATA_W];

    // carry out of the low nibble, carry in included
    wire logic [4:0] nib_full = awc_add5(op_dst_lo, op_src_lo, op_cin);
    wire logic half_out = nib_full[awc_pkg::NIB_W];

    wire logic dst_sign = awc_msb(op_dst);
    wire logic src_sign = awc_msb(op_src);
    wire logic sum_sign = awc_msb(sum);

    ////////////////////////////////////////////////////////////////////////
    // flag decode

    wire logic carry_new = carry_out;
    wire logic zero_new = awc_is_zero(sum);
    wire logic sign_new = sum_sign;
    wire logic ovf_new = awc_ovf(dst_sign, src_sign, sum_sign);
    wire logic dec_new = 1'b0;
    wire logic half_new = half_out;

    ////////////////////////////////////////////////////////////////////////
    // state registers

    logic valid_reg;
    logic [7:0] dst_reg;
    logic [7:0] src_reg;
    logic carry_reg;
    logic zero_reg;
    logic sign_reg;
    logic ovf_reg;
    logic dec_reg;
    logic half_reg;

    ////////////////////////////////////////////////////////////////////////
    // next values

    wire logic valid_next = take;
    // sum to destination, source echoed unchanged
    wire logic [7:0] dst_next = awc_hold8(take, sum, dst_reg);
    wire logic [7:0] src_next = awc_hold8(take, op_src, src_reg);
    wire logic carry_next = awc_hold1(take, carry_new, carry_reg);
    wire logic zero_next = awc_hold1(take, zero_new, zero_reg);
    wire logic sign_next = awc_hold1(take, sign_new, sign_reg);
    wire logic ovf_next = awc_hold1(take, ovf_new, ovf_reg);
    wire logic dec_next = awc_hold1(take, dec_new, dec_reg);
    wire logic half_next = awc_hold1(take, half_new, half_reg);

    ////////////////////////////////////////////////////////////////////////
    // write-back registers

    // valid, sum and flags share one edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dst_reg <= awc_pkg::RESULT_RST;
        end else begin
            dst_reg <= dst_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_reg <= awc_pkg::RESULT_RST;
        end else begin
            src_reg <= src_next;
        end
    end

    // flags, one register per bit, reset from the packed reset word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            carry_reg <= awc_pkg::FLAGS_RST[awc_pkg::FLAG_C_POS];
        end else begin
            carry_reg <= carry_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            zero_reg <= awc_pkg::FLAGS_RST[awc_pkg::FLAG_Z_POS];
        end else begin
            zero_reg <= zero_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sign_reg <= awc_pkg::FLAGS_RST[awc_pkg::FLAG_S_POS];
        end else begin
            sign_reg <= sign_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovf_reg <= awc_pkg::FLAGS_RST[awc_pkg::FLAG_V_POS];
        end else begin
            ovf_reg <= ovf_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dec_reg <= awc_pkg::FLAGS_RST[awc_pkg::FLAG_D_POS];
        end else begin
            dec_reg <= dec_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            half_reg <= awc_pkg::FLAGS_RST[awc_pkg::FLAG_H_POS];
        end else begin
            half_reg <= half_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, straight from the registers

    assign wb_valid = valid_reg;
    assign wb_dst_data = dst_reg;
    assign wb_src_data = src_reg;
    assign flags.c = carry_reg;
    assign flags.z = zero_reg;
    assign flags.s = sign_reg;
    assign flags.v = ovf_reg;
    assign flags.d = dec_reg;
    assign flags.h = half_reg;

endmodule // awc_alu

// File: rtl/awc_pkg.sv
package awc_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned MSB_POS = 7;
    localparam int unsigned NIB_W = 4;

    // flag positions inside the packed flag word
    localparam int unsigned FLAG_C_POS = 5;
    localparam int unsigned FLAG_Z_POS = 4;
    localparam int unsigned FLAG_S_POS = 3;
    localparam int unsigned FLAG_V_POS = 2;
    localparam int unsigned FLAG_D_POS = 1;
    localparam int unsigned FLAG_H_POS = 0;

    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;

    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
    } awc_flags_t;

    typedef struct packed {
        logic valid;
        logic [7:0] dst;
        logic [7:0] src;
        logic carry_in;
    } awc_req_t;

endpackage

// File: test/awc_alu_asserts.sv
`timescale 1ns/1ps
module awc_alu_asserts (
    input logic clk,
    input logic sys_rst,
    input awc_pkg::awc_req_t req,
    input logic wb_valid,
    input logic [7:0] wb_dst_data,
    input logic [7:0] wb_src_data,
    input awc_pkg::awc_flags_t flags
);
    wire tk = req.valid & ~sys_rst;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // a request taken at this edge
    sequence s_taken;
        tk;
    endsequence
    // no request at this edge
    sequence s_idle;
        !tk;
    endsequence
    a_sum_carry: assert property ($past(tk) |->
        {flags.c, wb_dst_data} == $past({1'b0, req.dst} + req.src + req.carry_in)) else $error("sum");
    a_zero_sign: assert property ($past(tk) |->
        flags.z == (wb_dst_data == 8'h00) && flags.s == wb_dst_data[7] && !flags.d) else $error("flags");
    a_src_kept: assert property (s_taken |=> wb_src_data == $past(req.src)) else $error("source changed");
    a_overflow_flag: assert property (s_taken |=>
        flags.v == ($past(req.dst[7]) == $past(req.src[7]) && wb_dst_data[7] != $past(req.dst[7])))
        else $error("overflow");
    a_half_carry: assert property (s_taken |=>
        flags.h == $past(({1'b0, req.dst[3:0]} + req.src[3:0] + req.carry_in) > 5'h0f)) else $error("half carry");
    a_valid_pulse: assert property (wb_valid == $past(tk)) else $error("valid pulse");
    a_idle_hold: assert property (s_idle |=>
        !wb_valid && $stable(wb_dst_data) && $stable(wb_src_data) && $stable(flags)) else $error("idle hold");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
        !wb_valid && wb_dst_data == 8'h00 && wb_src_data == 8'h00 && flags == 6'h00) else $error("reset clear");
endmodule // awc_alu_asserts
bind awc_alu awc_alu_asserts chk_u (.clk, .sys_rst, .req, .wb_valid, .wb_dst_data, .wb_src_data, .flags);

// File: test/awc_core_side.sv
`timescale 1ns/1ps
module awc_core_side (
    input awc_pkg::awc_flags_t flags,
    output logic cin
);
    assign cin = flags.c;
endmodule // awc_core_side

// File: test/test_add_with_carry_alu.sv
`timescale 1ns/1ps
module test_add_with_carry_alu;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cin;
    logic wv;
    logic [7:0] wd;
    logic [7:0] ws;
    awc_pkg::awc_flags_t fl;
    awc_pkg::awc_req_t req = '0;
    int n_mismatch = 0;
    int checked = 0;
    // row: carry in, dst, src, expected sum, expected flags c z s v d h
    logic [30:0] rw [7] = '{
        {1'b0, 8'hff, 8'h01, 8'h00, 6'h31},
        {1'b1, 8'h10, 8'h03, 8'h14, 6'h00},
        {1'b0, 8'h7f, 8'h01, 8'h80, 6'h0d},
        {1'b0, 8'h80, 8'h80, 8'h00, 6'h34},
        {1'b1, 8'h0f, 8'h00, 8'h10, 6'h01},
        {1'b0, 8'hff, 8'hff, 8'hfe, 6'h29},
        {1'b1, 8'h00, 8'h00, 8'h01, 6'h00}
    };

    awc_alu dut_u (
        .clk(clk),
        .sys_rst(sys_rst),
        .req(req),
        .wb_valid(wv),
        .wb_dst_data(wd),
        .wb_src_data(ws),
        .flags(fl)
    );

    awc_core_side core_u (
        .flags(fl),
        .cin(cin)
    );

    initial begin
        forever begin
            #2 clk = ~clk;
        end
    end

    task automatic cmp_bit(input logic g, input logic e, input string what);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t %s got %b want %b", $time, what, g, e);
        end
    endtask

    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e, input string what);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t %s got %h want %h", $time, what, g, e);
        end
    endtask

    task automatic cmp_flags(input logic [5:0] g, input logic [5:0] e, input string what);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t %s got %h want %h", $time, what, g, e);
        end
    endtask

    task automatic check_out(input logic v, input logic [7:0] d, input logic [7:0] s, input logic [5:0] f);
        cmp_bit(wv, v, "valid");
        cmp_byte(wd, d, "dst data");
        cmp_byte(ws, s, "src data");
        cmp_flags(fl, f, "flags");
    endtask

    task automatic tally_and_finish(input int late);
        n_mismatch += late;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // about 30 cycles of tests; the watchdog allows 500
    initial begin
        #2000;
        tally_and_finish(1);
    end

    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        check_out(1'b0, 8'h00, 8'h00, 6'h00);
        @(posedge clk);
        sys_rst <= 1'b0;
        $display("test reset done");
        foreach (rw[i]) begin
            @(posedge clk);
            cmp_bit(cin, rw[i][30], "carry chain");
            req <= '{valid: 1'b1, dst: rw[i][29:22], src: rw[i][21:14], carry_in: cin};
            @(posedge clk);
            req.valid <= 1'b0;
            @(negedge clk);
            check_out(1'b1, rw[i][13:6], rw[i][21:14], rw[i][5:0]);
        end
        $display("test table done");
        // back to back requests keep valid high
        @(posedge clk);
        req <= '{valid: 1'b1, dst: 8'h01, src: 8'h02, carry_in: 1'b0};
        @(posedge clk);
        req <= '{valid: 1'b1, dst: 8'h88, src: 8'h88, carry_in: 1'b1};
        @(negedge clk);
        check_out(1'b1, 8'h03, 8'h02, 6'h00);
        @(posedge clk);
        req <= '{valid: 1'b0, dst: 8'haa, src: 8'h55, carry_in: 1'b1};
        @(negedge clk);
        check_out(1'b1, 8'h11, 8'h88, 6'h25);
        $display("test back to back done");
        // idle cycles with changed operands hold the answer
        repeat (2) @(posedge clk);
        @(negedge clk);
        check_out(1'b0, 8'h11, 8'h88, 6'h25);
        $display("test idle hold done");
        // mid-run reset ignores a pending request and clears everything
        @(posedge clk);
        sys_rst <= 1'b1;
        req <= '{valid: 1'b1, dst: 8'hff, src: 8'hff, carry_in: 1'b1};
        repeat (2) @(posedge clk);
        @(negedge clk);
        check_out(1'b0, 8'h00, 8'h00, 6'h00);
        cmp_bit(cin, 1'b0, "carry after reset");
        @(posedge clk);
        sys_rst <= 1'b0;
        req <= '{valid: 1'b1, dst: 8'h10, src: 8'h03, carry_in: 1'b0};
        @(negedge clk);
        check_out(1'b0, 8'h00, 8'h00, 6'h00);
        @(posedge clk);
        req.valid <= 1'b0;
        @(negedge clk);
        check_out(1'b1, 8'h13, 8'h03, 6'h00);
        $display("test mid reset done");
        tally_and_finish(0);
    end
endmodule // test_add_with_carry_alu
